//--- design/smbc_regs.vh
// register layout and timing constants for the mode and burst configuration block
`ifndef SMBC_REGS_VH
`define SMBC_REGS_VH
`define SMBC_CFG_W        13
`define SMBC_BL_LSB       0
`define SMBC_BL_MSB       2
`define SMBC_ORDER_BIT    3
`define SMBC_LAT_LSB      4
`define SMBC_LAT_MSB      6
`define SMBC_OPM_LO_BIT   7
`define SMBC_OPM_HI_BIT   8
`define SMBC_WSINGLE_BIT  9
`define SMBC_BL_1         3'h0
`define SMBC_BL_2         3'h1
`define SMBC_BL_4         3'h2
`define SMBC_BL_8         3'h3
`define SMBC_BL_PAGE      3'h7
`define SMBC_LAT_2        3'h2
`define SMBC_LAT_3        3'h3
`define SMBC_CFG_RESET    13'h0020
`define SMBC_COL_W        11
`define SMBC_CMD_W        3
`define SMBC_CMD_NOP      3'h0
`define SMBC_CMD_LOAD     3'h1
`define SMBC_CMD_READ     3'h2
`define SMBC_CMD_WRITE    3'h3
`define SMBC_CMD_STOP     3'h4
`endif

//--- design/smbc_top.v
// mode configuration register with burst column sequencing and read latency timing
`timescale 1ns/1ps
`include "smbc_regs.vh"

module smbc_top (
  input  wire                   MCLK,
  input  wire                   RST_N,
  input  wire [`SMBC_CMD_W-1:0] CMD,
  input  wire                   BANK_SEL_0,
  input  wire                   BANK_SEL_1,
  input  wire [12:0]            ADDR,
  input  wire [1:0]             ROW_SIZE,
  output reg  [`SMBC_CFG_W-1:0] CFG_OUT,
  output reg  [`SMBC_COL_W-1:0] COL_ADDR,
  output reg                    COL_VALID,
  output reg                    COL_IS_WRITE,
  output reg                    DQ_DRIVE,
  output reg                    DQ_VALID,
  output reg                    CFG_ILLEGAL
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_BURST = 3'b010;
  localparam [2:0] ST_PAGE  = 3'b100;

  reg  [`SMBC_CFG_W-1:0] cfg_q;
  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg  [`SMBC_COL_W-1:0] base_q;
  reg  [`SMBC_COL_W-1:0] page_q;
  reg  [2:0]             start_q;
  reg  [2:0]             idx_q;
  reg  [2:0]             last_q;
  reg  [2:0]             mask_q;
  reg                    wr_q;
  reg  [3:0]             rd_pipe_q;
  reg  [`SMBC_COL_W-1:0] page_mask;
  reg  [2:0]             len_mask;
  reg  [2:0]             off;
  reg                    bl_ok;
  reg                    lat_ok;

  wire [2:0] bl_code  = cfg_q[`SMBC_BL_MSB:`SMBC_BL_LSB];
  wire [2:0] lat_code = cfg_q[`SMBC_LAT_MSB:`SMBC_LAT_LSB];
  wire       order_il = cfg_q[`SMBC_ORDER_BIT];
  wire       wsingle  = cfg_q[`SMBC_WSINGLE_BIT];
  wire       is_load  = (CMD == `SMBC_CMD_LOAD) && !BANK_SEL_0 && !BANK_SEL_1;
  wire       is_rd    = (CMD == `SMBC_CMD_READ);
  wire       is_wr    = (CMD == `SMBC_CMD_WRITE);
  wire       start    = is_rd || is_wr;
  wire       single   = is_wr && wsingle;
  wire       lat3     = (lat_code == `SMBC_LAT_3);

  // row width set by device organisation: 2048, 1024 or 512 columns
  always @* begin
    case (ROW_SIZE)
      2'h0:    page_mask = 11'h7ff;
      2'h1:    page_mask = 11'h3ff;
      default: page_mask = 11'h1ff;
    endcase
  end

  always @* begin
    case (bl_code)
      `SMBC_BL_2: len_mask = 3'h1;
      `SMBC_BL_4: len_mask = 3'h3;
      `SMBC_BL_8: len_mask = 3'h7;
      default:    len_mask = 3'h0;
    endcase
  end

  // interleave is xor of start and index; sequential is their masked sum
  always @* begin
    if (order_il)
      off = (start_q ^ idx_q) & mask_q;
    else
      off = (start_q + idx_q) & mask_q;
  end

  // reserved length and latency codes are stored as given but flagged
  always @* begin
    case (ADDR[2:0])
      `SMBC_BL_1:    bl_ok = 1'b1;
      `SMBC_BL_2:    bl_ok = 1'b1;
      `SMBC_BL_4:    bl_ok = 1'b1;
      `SMBC_BL_8:    bl_ok = 1'b1;
      `SMBC_BL_PAGE: bl_ok = !ADDR[3];
      default:       bl_ok = 1'b0;
    endcase
  end

  always @* begin
    case (ADDR[6:4])
      `SMBC_LAT_2: lat_ok = 1'b1;
      `SMBC_LAT_3: lat_ok = 1'b1;
      default:     lat_ok = 1'b0;
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  state_d = ST_IDLE;
      ST_BURST: begin
        if (CMD == `SMBC_CMD_STOP || idx_q == last_q)
          state_d = ST_IDLE;
      end
      ST_PAGE: begin
        if (CMD == `SMBC_CMD_STOP)
          state_d = ST_IDLE;
      end
      default:  state_d = ST_IDLE;
    endcase
    // a new read or write outranks the end of a running burst in the same cycle
    if (start && !single && bl_code == `SMBC_BL_PAGE)
      state_d = ST_PAGE;
    else if (start && !single && len_mask != 3'h0)
      state_d = ST_BURST;
    else if (start)
      state_d = ST_IDLE;
  end

  // only a load touches the register; it holds otherwise
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q       <= `SMBC_CFG_RESET;
      CFG_OUT     <= `SMBC_CFG_RESET;
      CFG_ILLEGAL <= 1'b0;
    end else begin
      if (is_load) begin
        cfg_q       <= {1'b0, ADDR[11:0]};
        CFG_ILLEGAL <= ADDR[8] | ADDR[7] | ADDR[12] | !bl_ok | !lat_ok;
      end
      CFG_OUT <= cfg_q;
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q      <= ST_IDLE;
      base_q       <= 11'h000;
      page_q       <= 11'h000;
      start_q      <= 3'h0;
      idx_q        <= 3'h0;
      last_q       <= 3'h0;
      mask_q       <= 3'h0;
      wr_q         <= 1'b0;
      COL_ADDR     <= 11'h000;
      COL_VALID    <= 1'b0;
      COL_IS_WRITE <= 1'b0;
    end else begin
      state_q   <= state_d;
      COL_VALID <= 1'b0;
      if (start) begin
        COL_VALID    <= 1'b1;
        COL_IS_WRITE <= is_wr;
        wr_q         <= is_wr;
        idx_q        <= 3'h1;
        page_q       <= (ADDR[10:0] + 11'h001) & page_mask;
        // single-column access uses the column bits within the row width set by page_mask
        if (single || len_mask == 3'h0 || bl_code == `SMBC_BL_PAGE) begin
          COL_ADDR <= ADDR[10:0] & page_mask;
        end else begin
          base_q   <= ADDR[10:0] & ~{8'h00, len_mask};
          start_q  <= ADDR[2:0] & len_mask;
          mask_q   <= len_mask;
          last_q   <= len_mask;
          COL_ADDR <= ADDR[10:0] & page_mask;
        end
      end else if (state_q == ST_BURST && CMD != `SMBC_CMD_STOP) begin
        COL_VALID    <= 1'b1;
        COL_IS_WRITE <= wr_q;
        COL_ADDR     <= (base_q | {8'h00, off}) & page_mask;
        idx_q        <= idx_q + 3'h1;
      end else if (state_q == ST_PAGE && state_d == ST_PAGE) begin
        // page counter advances while the page burst runs; every read or write start also reloads it
        COL_VALID    <= 1'b1;
        COL_IS_WRITE <= wr_q;
        COL_ADDR     <= page_q;
        page_q       <= (page_q + 11'h001) & page_mask;
      end
    end
  end

  // read column issue shifted by latency; drive one edge before valid
  // latency comes from the stored code, so a load mid-burst retimes reads
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_pipe_q <= 4'h0;
      DQ_DRIVE  <= 1'b0;
      DQ_VALID  <= 1'b0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[2:0], COL_VALID & !COL_IS_WRITE};
      DQ_DRIVE  <= lat3 ? rd_pipe_q[0] : (COL_VALID & !COL_IS_WRITE);
      DQ_VALID  <= lat3 ? rd_pipe_q[1] : rd_pipe_q[0];
    end
  end

endmodule // smbc_top

//--- sim/smbc_checker.sv
// concurrent checks on the mode and burst configuration block
`timescale 1ns/1ps
module smbc_checker (
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic [2:0]  CMD,
  input wire logic        BANK_SEL_0,
  input wire logic        BANK_SEL_1,
  input wire logic [12:0] ADDR,
  input wire logic [12:0] CFG_OUT,
  input wire logic [10:0] COL_ADDR,
  input wire logic        COL_VALID,
  input wire logic        COL_IS_WRITE,
  input wire logic        DQ_DRIVE,
  input wire logic        DQ_VALID
);
  wire         ld = CMD == 3'h1 && !BANK_SEL_0 && !BANK_SEL_1;
  wire         rd = CMD == 3'h2;
  wire         wr = CMD == 3'h3;
  wire         nop = CMD == 3'h0;
  logic [11:0] cfg_q;
  // copy lags a load by up to two edges, so compare after three quiet ones
  always @(posedge MCLK or negedge RST_N)
    if (!RST_N) cfg_q <= 12'h020;
    else if (ld) cfg_q <= ADDR[11:0];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_cfg; (!ld) [*3] |-> CFG_OUT[11:0] == cfg_q; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  property p_first; rd || wr |-> ##1 COL_VALID && COL_ADDR[8:0] == $past(ADDR[8:0], 1); endproperty
  a_first: assert property (p_first) else $error("first col");
  property p_kind; rd || wr |-> ##1 COL_IS_WRITE == $past(wr, 1); endproperty
  a_kind: assert property (p_kind) else $error("kind");
  property p_lat2; rd && CFG_OUT[6:4] == 3'h2 |-> ##2 DQ_DRIVE ##1 DQ_VALID; endproperty
  a_lat2: assert property (p_lat2) else $error("lat2");
  property p_lat3; rd && CFG_OUT[6:4] == 3'h3 |-> ##2 !DQ_VALID ##1 DQ_DRIVE ##1 DQ_VALID; endproperty
  a_lat3: assert property (p_lat3) else $error("lat3");
  property p_seq4; rd && CFG_OUT[3:0] == 4'h2 ##1 nop [*2] |-> ##1 COL_ADDR[1:0] == $past(ADDR[1:0], 3) + 2'h2; endproperty
  a_seq4: assert property (p_seq4) else $error("seq4");
  property p_single; wr && CFG_OUT[9] ##1 nop [*2] |-> ##1 !COL_VALID; endproperty
  a_single: assert property (p_single) else $error("single");
  property p_stop; CMD == 3'h4 ##1 nop |-> ##1 !COL_VALID; endproperty
  a_stop: assert property (p_stop) else $error("stop");
endmodule // smbc_checker
bind smbc_top smbc_checker smbc_checker_i (.*);

//--- sim/smbc_ctl.sv
// controller model driving commands into the configuration block
`timescale 1ns/1ps
module smbc_ctl (
  input  wire logic   MCLK,
  output logic [2:0]  CMD,
  output logic [12:0] ADDR,
  output logic        BANK_SEL_0,
  output logic        BANK_SEL_1
);
  initial {CMD, ADDR, BANK_SEL_0, BANK_SEL_1} = '0;
  // callers give gap >= 3 after loads; the bench's last load (11'h0a2) sets reserved bit 7
  task automatic op(input logic [2:0] c, input logic [9:0] a, input logic b, input int gap);
    @(posedge MCLK);
    CMD <= c;
    ADDR <= {3'h0, a};
    BANK_SEL_0 <= b;
    BANK_SEL_1 <= b;
    repeat (gap) begin
      @(posedge MCLK);
      CMD <= 3'h0;
      ADDR <= ~ADDR;
    end
  endtask
endmodule // smbc_ctl

//--- sim/tb_sdram_mode_burst_config.sv
// self-checking bench for the mode and burst configuration block
`timescale 1ns/1ps
module tb_sdram_mode_burst_config;
  logic        MCLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [1:0]  ROW_SIZE = 2'h0;
  wire  [2:0]  CMD;
  wire  [12:0] ADDR, CFG_OUT;
  wire  [10:0] COL_ADDR;
  wire         BANK_SEL_0, BANK_SEL_1, COL_VALID, COL_IS_WRITE, DQ_DRIVE, DQ_VALID, CFG_ILLEGAL;
  logic [11:0] exp_q[$];
  logic [31:0] rs = 32'hebeb83d8, r;
  int          errors = 0, n_checks = 0, n;
  always #5 MCLK = ~MCLK;
  smbc_top smbc_top_i (.*);
  smbc_ctl smbc_ctl_i (.*);
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // note cnt expected columns in a block of m, then issue
  task go(input logic [2:0] c, input logic [10:0] s, input int cnt, input int m, input logic il, input int gap);
    for (int k = 0; k < cnt; k++)
      exp_q.push_back({c == 3'h3, il ? s ^ 11'(k) : (s & ~11'(m - 1)) | ((s + 11'(k)) & 11'(m - 1))});
    smbc_ctl_i.op(c, s[9:0], 1'b0, gap);
  endtask
  always @(negedge MCLK)
    if (COL_VALID === 1'b1) chk("col", {1'b0, exp_q.size() > 0 ? exp_q.pop_front() : 12'hfff}, {1'b0, COL_IS_WRITE, COL_ADDR});
  initial begin
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    chk("reset cfg", 13'h0020, CFG_OUT);
    for (int i = 0; i < 16; i++) begin
      n = 1 << i[1:0];
      r = rnd();
      go(3'h1, {1'b0, r[0], 2'h0, 2'h1, i[3], i[2], 1'b0, i[1:0]}, 0, 1, 1'b0, 3);
      go(3'h2, {1'b0, r[19:10]}, n, n, i[2], n + 4);
      go(3'h3, {1'b0, r[29:20]}, r[0] ? 1 : n, r[0] ? 1 : n, i[2], n + 2);
      $display("mode test %0d done", i);
    end
    ROW_SIZE <= 2'h1;
    go(3'h1, 11'h027, 0, 1, 1'b0, 3);
    go(3'h2, 11'd1022, 4, 1024, 1'b0, 3);
    go(3'h4, 11'h0, 0, 1, 1'b0, 4);
    smbc_ctl_i.op(3'h1, 10'h032, 1'b1, 3);
    @(negedge MCLK);
    chk("cfg", 13'h0027, CFG_OUT);
    go(3'h1, 11'h0a2, 0, 1, 1'b0, 3);
    @(negedge MCLK);
    chk("illegal", 13'h1, {12'h0, CFG_ILLEGAL});
    chk("left", 13'h0, 13'(exp_q.size()));
    $display("page and load tests done");
    report_and_stop();
  end
  initial begin
    #50000;
    errors++;
    report_and_stop();
  end
endmodule // tb_sdram_mode_burst_config
